// file: dv/tb.sv
// Self-checking bench for the opcode decoder and its timing lookup
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Expected result of one decoded instruction
  typedef struct packed {
    xodt_pkg::xodt_op_t op;
    logic [4:0] clk;
    logic [7:0] modrm;
    logic two;
    logic unk;
  } xodt_exp_t;
  `define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
  // Clock, reset and stimulus controls
  logic core_clk = 1'b0;
  logic rst, clk_en, gap, prot_mode, pm, slow, freeze;
  logic byte_valid, dec_valid, dec_two_byte, dec_unknown;
  logic [7:0] byte_data, dec_modrm;
  logic [4:0] dec_clocks;
  xodt_pkg::xodt_op_t dec_op;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] seed = 32'hE571;
  logic [31:0] stall_rv;
  xodt_exp_t exp_q[$];
  xodt_exp_t e;
  // Directed table: opcode pair (single-byte forms in the upper byte) and reg field
  logic [15:0] op_tab [22] = '{16'h7A00, 16'h0F8A, 16'h9F00, 16'h0F02, 16'hC500, 16'hC400, 16'h0FB4,
    16'h0FB5, 16'h0FB2, 16'h0F01, 16'h0F01, 16'h0F00, 16'h0F00, 16'h0F01, 16'h0F03, 16'h8D00,
    16'hC900, 16'hE200, 16'h0F01, 16'h0F00, 16'h0FFF, 16'h9000};
  logic [2:0] reg_tab [22] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3,
    3'h2, 3'h3, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h7, 3'h0, 3'h0};
  ////////////////////////////////////////////////////////////////
  xodt_decoder dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .byte_valid(byte_valid),
    .byte_data(byte_data), .prot_mode(prot_mode), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_clocks(dec_clocks), .dec_modrm(dec_modrm), .dec_two_byte(dec_two_byte),
    .dec_unknown(dec_unknown));
  xodt_fetch_model fetch (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .gap(gap),
    .byte_valid(byte_valid), .byte_data(byte_data));
  ////////////////////////////////////////////////////////////////
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Class and count pair
  function automatic xodt_exp_t cls(input xodt_pkg::xodt_op_t o, input logic [4:0] c);
    cls = '{o, c, 8'h00, 1'b0, 1'b0};
  endfunction
  // Reference decode; n returns the byte count
  function automatic xodt_exp_t model(input logic [7:0] b0, b1, m, input logic p, output int n);
    xodt_exp_t r;
    logic two;
    logic [7:0] o;
    logic [2:0] rg;
    two = (b0 == 8'h0F);
    o = two ? b1 : b0;
    rg = m[5:3];
    r = cls(xodt_pkg::XODT_OP_NONE, 5'h00);
    if (two) begin
      case (o)
        8'h8A: r = cls(xodt_pkg::XODT_OP_JUMP_PARITY_EVEN, 5'h01);
        8'h02: if (p) r = cls(xodt_pkg::XODT_OP_LOAD_ACCESS_RIGHTS, 5'h09);
        8'h03: if (p) r = cls(xodt_pkg::XODT_OP_SEGMENT_LIMIT_LOAD, 5'h09);
        8'hB4: r = cls(xodt_pkg::XODT_OP_FAR_PTR_LOAD_F_SEG, p ? 5'h09 : 5'h04);
        8'hB5: r = cls(xodt_pkg::XODT_OP_FAR_PTR_LOAD_G_SEG, p ? 5'h09 : 5'h04);
        8'hB2: r = cls(xodt_pkg::XODT_OP_FAR_PTR_LOAD_STACK_SEG, p ? 5'h0A : 5'h04);
        8'h00: begin
          if (p && rg == 3'h2) r = cls(xodt_pkg::XODT_OP_LOCAL_DT_LOAD, 5'h08);
          if (p && rg == 3'h3) r = cls(xodt_pkg::XODT_OP_TASK_REGISTER_LOAD, 5'h09);
        end
        8'h01: begin
          if (rg == 3'h2) r = cls(xodt_pkg::XODT_OP_GLOBAL_DT_LOAD, 5'h0A);
          if (rg == 3'h3) r = cls(xodt_pkg::XODT_OP_INTERRUPT_DT_LOAD, 5'h0A);
          if (rg == 3'h6) r = cls(xodt_pkg::XODT_OP_MACHINE_STATUS_WORD_LOAD, 5'h0B);
        end
        default: r.op = xodt_pkg::XODT_OP_NONE;
      endcase
    end else begin
      case (o)
        8'h7A: r = cls(xodt_pkg::XODT_OP_JUMP_PARITY_EVEN, 5'h01);
        8'h9F: r = cls(xodt_pkg::XODT_OP_FLAGS_TO_ACCUM_HIGH, 5'h02);
        8'hC5: r = cls(xodt_pkg::XODT_OP_FAR_PTR_LOAD_DATA_SEG, p ? 5'h09 : 5'h04);
        8'hC4: r = cls(xodt_pkg::XODT_OP_FAR_PTR_LOAD_EXTRA_SEG, p ? 5'h09 : 5'h04);
        8'h8D: r = cls(xodt_pkg::XODT_OP_EFFECTIVE_ADDRESS_COMPUTE, 5'h01);
        8'hC9: r = cls(xodt_pkg::XODT_OP_FRAME_EXIT, 5'h04);
        8'hE2: r = cls(xodt_pkg::XODT_OP_COUNTED_LOOP, 5'h02);
        default: r.op = xodt_pkg::XODT_OP_NONE;
      endcase
    end
    r.two = two;
    r.unk = (r.op == xodt_pkg::XODT_OP_NONE);
    n = two ? 2 : 1;
    if (two ? (o inside {8'h00, 8'h01, 8'h02, 8'h03, 8'hB2, 8'hB4, 8'hB5}) : (o inside {8'hC4, 8'hC5, 8'h8D})) begin
      n++;
      r.modrm = m;
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////
  // Queue the bytes of one instruction and its expectation
  task automatic send(input logic [7:0] b0, b1, m);
    int n;
    exp_q.push_back(model(b0, b1, m, pm, n));
    fetch.push(b0);
    if (b0 == 8'h0F) fetch.push(b1);
    if (n > ((b0 == 8'h0F) ? 2 : 1)) fetch.push(m);
  endtask
  // Wait, bounded, until every expectation was met
  task automatic drain();
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  always #5 core_clk = ~core_clk;
  // Random stalls of the fetch side and clock-enable freezes
  always @(posedge core_clk) begin
    stall_rv = rnd();
    gap <= slow & stall_rv[3];
    clk_en <= freeze ? (stall_rv[1:0] != 2'b00) : 1'b1;
  end
  // Compare each reported instruction with the reference
  always @(posedge core_clk) begin
    if (!rst && dec_valid && clk_en) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        `CHK(dec_op, e.op)
        `CHK(dec_clocks, e.clk)
        `CHK({dec_modrm, dec_two_byte, dec_unknown}, {e.modrm, e.two, e.unk})
      end
    end
  end
  // Hang guard
  initial begin
    #500us;
    err_total++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    prot_mode = 1'b0;
    pm = 1'b0;
    slow = 1'b0;
    freeze = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // Every table entry back to back in both modes, then random traffic with stalls
    for (int ph = 0; ph < 4; ph++) begin
      @(posedge core_clk);
      pm = ph[0];
      prot_mode <= ph[0];
      slow = ph[1];
      freeze = ph[1];
      for (int i = 0; i < (ph[1] ? 200 : 22); i++) begin
        int k;
        logic [31:0] r;
        r = rnd();
        k = ph[1] ? (r[31:16] % 22) : i;
        if (ph[1] && r[4]) send(r[7:0], r[15:8], r[23:16]);
        else send(op_tab[k][15:8], op_tab[k][7:0], {r[7:6], (k < 9 || k > 13) && k < 18 ? r[5:3] : reg_tab[k], r[2:0]});
      end
      drain();
    end
    // Reset in the middle of a two-byte form
    slow = 1'b0;
    freeze = 1'b0;
    fetch.push(8'h0F);
    repeat (3) @(posedge core_clk);
    rst <= 1'b1;
    fetch.flush();
    @(negedge core_clk);
    `CHK({dec_valid, dec_op, dec_clocks, dec_unknown}, 12'h000)
    @(posedge core_clk);
    rst <= 1'b0;
    send(8'h9F, 8'h00, 8'h00);
    drain();
    print_verdict();
  end
endmodule

// file: dv/xodt_fetch_model.sv
// Fetch-stage model that feeds instruction bytes to the decoder
module xodt_fetch_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic gap,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bytes still waiting to be offered
  logic [7:0] pend[$];
  ////////////////////////////////////////////////////////////////
  // Queue one byte for delivery
  task automatic push(input logic [7:0] b);
    pend.push_back(b);
  endtask
  // Drop all bytes not yet offered
  task automatic flush();
    pend.delete();
  endtask
  ////////////////////////////////////////////////////////////////
  // One byte per cycle, held until a clock-enabled edge takes it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_data <= 8'hA5;
    end else if (byte_valid && !clk_en) begin
      // Not taken yet: hold byte and valid
    end else if (pend.size() != 0 && !gap) begin
      byte_valid <= 1'b1;
      byte_data <= pend.pop_front();
    end else begin
      // Idle: stale data is scrambled so it cannot be mistaken for a byte
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  end
endmodule

// file: inc/xodt_params.svh
// Constants for the opcode decode and timing block
`ifndef XODT_PARAMS_SVH
`define XODT_PARAMS_SVH
// Opcode bytes
`define XODT_OP_PREFIX 8'h0F
`define XODT_OP_PAR_JMP_SHORT 8'h7A
`define XODT_OP_PAR_JMP_NEAR 8'h8A
`define XODT_OP_FLAGS_AH 8'h9F
`define XODT_OP_ACC_RIGHTS 8'h02
`define XODT_OP_SEG_LIMIT 8'h03
`define XODT_OP_GRP_SYS0 8'h00
`define XODT_OP_GRP_SYS1 8'h01
`define XODT_OP_PTR_DS 8'hC5
`define XODT_OP_PTR_ES 8'hC4
`define XODT_OP_PTR_FS 8'hB4
`define XODT_OP_PTR_GS 8'hB5
`define XODT_OP_PTR_SS 8'hB2
`define XODT_OP_EFF_ADDR 8'h8D
`define XODT_OP_FRAME_EXIT 8'hC9
`define XODT_OP_LOOP 8'hE2
// Reg-field selectors
`define XODT_REG_GDT 3'h2
`define XODT_REG_IDT 3'h3
`define XODT_REG_LDT 3'h2
`define XODT_REG_TASK 3'h3
`define XODT_REG_MSW 3'h6
// Clock counts, real and protected
`define XODT_CLK_PAR_JMP 5'h01
`define XODT_CLK_FLAGS_AH 5'h02
`define XODT_CLK_ACC_RIGHTS_P 5'h09
`define XODT_CLK_PTR_R 5'h04
`define XODT_CLK_PTR_P 5'h09
`define XODT_CLK_PTR_SS_P 5'h0A
`define XODT_CLK_DTAB 5'h0A
`define XODT_CLK_LDT_P 5'h08
`define XODT_CLK_TASK_P 5'h09
`define XODT_CLK_MSW 5'h0B
`define XODT_CLK_SEG_LIMIT_P 5'h09
`define XODT_CLK_EFF_ADDR 5'h01
`define XODT_CLK_FRAME_EXIT 5'h04
`define XODT_CLK_LOOP 5'h02
`endif

// file: inc/xodt_pkg.sv
// Types for the opcode decode and timing block
package xodt_pkg;
  // Decoded operation classes
  typedef enum logic [4:0] {
    XODT_OP_NONE = 5'h00,
    XODT_OP_JUMP_PARITY_EVEN = 5'h01,
    XODT_OP_FLAGS_TO_ACCUM_HIGH = 5'h02,
    XODT_OP_LOAD_ACCESS_RIGHTS = 5'h03,
    XODT_OP_FAR_PTR_LOAD_DATA_SEG = 5'h04,
    XODT_OP_FAR_PTR_LOAD_EXTRA_SEG = 5'h05,
    XODT_OP_FAR_PTR_LOAD_F_SEG = 5'h06,
    XODT_OP_FAR_PTR_LOAD_G_SEG = 5'h07,
    XODT_OP_FAR_PTR_LOAD_STACK_SEG = 5'h08,
    XODT_OP_GLOBAL_DT_LOAD = 5'h09,
    XODT_OP_INTERRUPT_DT_LOAD = 5'h0A,
    XODT_OP_LOCAL_DT_LOAD = 5'h0B,
    XODT_OP_TASK_REGISTER_LOAD = 5'h0C,
    XODT_OP_MACHINE_STATUS_WORD_LOAD = 5'h0D,
    XODT_OP_SEGMENT_LIMIT_LOAD = 5'h0E,
    XODT_OP_EFFECTIVE_ADDRESS_COMPUTE = 5'h0F,
    XODT_OP_FRAME_EXIT = 5'h10,
    XODT_OP_COUNTED_LOOP = 5'h11
  } xodt_op_t;
  // Byte collection states, one-hot
  typedef enum logic [2:0] {
    XODT_ST_FIRST = 3'b001,
    XODT_ST_SECOND = 3'b010,
    XODT_ST_MODRM = 3'b100
  } xodt_state_t;
endpackage

// file: verilog/xodt_decoder.sv
// Opcode decoder with per-mode issue timing for a core instruction slice
//
// What this block does
// - 7A or 0F 8A: parity jump, 1 clock
// - 9F: flags to AH, 2 clocks
// - 0F 02: access rights load, 9 protected
// - C5: data segment pointer, 4/9
// - C4: extra segment pointer, 4/9
// - 0F B4: FS pointer load, 4/9
// - 0F B5: GS pointer load, 4/9
// - 0F B2: stack segment pointer, 4/10
// - 0F 01 reg 010: GDT load, 10
// - 0F 01 reg 011: IDT load, 10
// - 0F 00 reg 010: LDT load, 8 protected
// - 0F 00 reg 011: task register, 9 protected
// - 0F 01 reg 110: status word, 11
// - 0F 03: segment limit load, 9 protected
// - 8D: effective address, 1 clock
// - C9: stack frame exit, 4 clocks
// - E2: counted loop, 2 clocks
`include "xodt_params.svh"
module xodt_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic prot_mode,
  output logic dec_valid,
  output xodt_pkg::xodt_op_t dec_op,
  output logic [4:0] dec_clocks,
  output logic [7:0] dec_modrm,
  output logic dec_two_byte,
  output logic dec_unknown
);
  //////////////////////////////////////////////////////////////////////////////
  // State
  xodt_pkg::xodt_state_t state; // Byte collection state
  xodt_pkg::xodt_state_t next_state; // Next collection state
  logic two_byte; // Prefix seen
  logic [7:0] opcode; // Held opcode byte
  logic next_two_byte;
  logic [7:0] next_opcode;

  //////////////////////////////////////////////////////////////////////////////
  // Decode network
  wire logic [7:0] map_opcode; // Opcode presented to the map
  wire logic map_two_byte; // Table select
  wire logic [2:0] map_reg; // Reg field of mod-r/m
  xodt_pkg::xodt_op_t map_op; // Class
  logic map_modrm; // Class needs mod-r/m
  logic [4:0] map_clocks; // Clocks for mode
  logic map_prot_only; // Defined only in protected mode
  wire logic at_first; // First byte cycle
  wire logic at_second; // Byte after prefix
  wire logic at_modrm; // Mod-r/m cycle
  wire logic is_prefix; // Byte is the two-byte escape
  wire logic finish; // Instruction completes now
  wire logic known; // Class recognised and legal in mode

  // One-hot state taps
  assign at_first = (state == xodt_pkg::XODT_ST_FIRST);
  assign at_second = (state == xodt_pkg::XODT_ST_SECOND);
  assign at_modrm = (state == xodt_pkg::XODT_ST_MODRM);
  // Escape counts only as a first byte
  assign is_prefix = at_first && (byte_data == `XODT_OP_PREFIX);
  // Mod-r/m cycle decodes the held opcode
  assign map_opcode = at_modrm ? opcode : byte_data;
  assign map_two_byte = at_modrm ? two_byte : at_second;
  // Reg field, meaningful in the mod-r/m cycle
  assign map_reg = byte_data[5:3];
  // Last byte of the form taken
  assign finish = byte_valid && !is_prefix && (at_modrm || !map_modrm);
  // Protected-only classes fail in real mode
  assign known = (map_op != xodt_pkg::XODT_OP_NONE) && !(map_prot_only && !prot_mode);

  // Opcode class lookup
  xodt_opmap u_opmap (
    .two_byte(map_two_byte),
    .opcode(map_opcode),
    .reg_field(map_reg),
    .op(map_op),
    .needs_modrm(map_modrm)
  );

  // Clock count lookup, mode selected
  xodt_timing u_timing (
    .op(map_op),
    .prot_mode(prot_mode),
    .clocks(map_clocks),
    .prot_only(map_prot_only)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    next_two_byte = two_byte;
    next_opcode = opcode;
    if (byte_valid) begin
      case (state)
        // Opcode or prefix
        xodt_pkg::XODT_ST_FIRST: begin
          next_two_byte = is_prefix;
          next_opcode = byte_data;
          if (is_prefix) next_state = xodt_pkg::XODT_ST_SECOND;
          else if (map_modrm) next_state = xodt_pkg::XODT_ST_MODRM;
        end
        // Second opcode byte
        xodt_pkg::XODT_ST_SECOND: begin
          next_opcode = byte_data;
          next_state = map_modrm ? xodt_pkg::XODT_ST_MODRM : xodt_pkg::XODT_ST_FIRST;
        end
        // Mod-r/m ends the opcode portion
        xodt_pkg::XODT_ST_MODRM: next_state = xodt_pkg::XODT_ST_FIRST;
        default: next_state = xodt_pkg::XODT_ST_FIRST;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Collection registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= xodt_pkg::XODT_ST_FIRST;
      two_byte <= 1'b0;
      opcode <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      two_byte <= next_two_byte;
      opcode <= next_opcode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers, one-cycle result per instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_op <= xodt_pkg::XODT_OP_NONE;
      dec_clocks <= 5'h00;
      dec_modrm <= 8'h00;
      dec_two_byte <= 1'b0;
      dec_unknown <= 1'b0;
    end else if (clk_en) begin
      dec_valid <= finish;
      if (finish) begin
        dec_op <= known ? map_op : xodt_pkg::XODT_OP_NONE;
        dec_clocks <= known ? map_clocks : 5'h00;
        dec_modrm <= at_modrm ? byte_data : 8'h00;
        dec_two_byte <= map_two_byte;
        dec_unknown <= !known;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Prefix byte, then the given second byte next cycle
  sequence s_prefix_then(logic [7:0] b);
    clk_en && byte_valid && at_first && byte_data == 8'h0F
      ##1 clk_en && byte_valid && at_second && byte_data == b;
  endsequence

  // One opcode byte taken as a first byte
  sequence s_first_is(logic [7:0] b);
    clk_en && byte_valid && at_first && byte_data == b;
  endsequence

  // Mod-r/m byte taken
  sequence s_modrm_taken;
    clk_en && byte_valid && at_modrm;
  endsequence

  // Short parity jump, one clock
  AST_PAR_JMP_SHORT: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'h7A) |=> dec_valid && dec_clocks == 5'h01)
    else $error("short parity jump count wrong");

  // Near parity jump ends on its second byte
  AST_PAR_JMP_NEAR: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_second && byte_data == 8'h8A
    |=> dec_valid && dec_clocks == 5'h01 && dec_op == xodt_pkg::XODT_OP_JUMP_PARITY_EVEN)
    else $error("near parity jump not decoded");

  // Escape byte alone reports nothing
  AST_PREFIX_WAITS: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'h0F) |=> !dec_valid && at_second)
    else $error("escape byte reported as an instruction");

  // Unknown second byte ends at once with no count
  AST_PREFIX_UNKNOWN: assert property (@(posedge core_clk) disable iff (rst)
    s_prefix_then(8'hFF) |=> dec_valid && dec_unknown && dec_two_byte && dec_clocks == 5'h00)
    else $error("unknown two-byte form not flagged");

  // Flags to accumulator high byte
  AST_FLAGS_AH: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'h9F) |=> dec_valid && dec_clocks == 5'h02)
    else $error("flags to AH count wrong");

  // Access rights load, protected only
  AST_ACC_RIGHTS: assert property (@(posedge core_clk) disable iff (rst)
    s_prefix_then(8'h02) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h00))
    else $error("access rights load count wrong");

  // Data segment pointer
  AST_PTR_DS: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'hC5) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h04))
    else $error("data segment pointer count wrong");

  // Extra segment pointer
  AST_PTR_ES: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'hC4) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h04))
    else $error("extra segment pointer count wrong");

  // F segment pointer
  AST_PTR_FS: assert property (@(posedge core_clk) disable iff (rst)
    s_prefix_then(8'hB4) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h04))
    else $error("f segment pointer count wrong");

  // G segment pointer
  AST_PTR_GS: assert property (@(posedge core_clk) disable iff (rst)
    s_prefix_then(8'hB5) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h04))
    else $error("g segment pointer count wrong");

  // Stack segment pointer, protected count
  AST_PTR_SS: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'hB2 && prot_mode |=> dec_clocks == 5'h0A)
    else $error("stack segment pointer count wrong");

  // Global table load
  AST_GDT_SEQ: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h01 && byte_data[5:3] == 3'h2
    |=> dec_clocks == 5'h0A)
    else $error("descriptor table load count wrong");

  // Interrupt table load
  AST_IDT: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h01 && byte_data[5:3] == 3'h3
    |=> dec_valid && dec_clocks == 5'h0A)
    else $error("interrupt table load count wrong");

  // System group 0 refused in real mode
  AST_LDT_REAL: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h00 && !prot_mode |=> dec_unknown)
    else $error("protected-only load accepted in real mode");

  // Local table load, protected
  AST_LDT_PROT: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h00 && byte_data[5:3] == 3'h2 && prot_mode
    |=> dec_valid && dec_clocks == 5'h08)
    else $error("local table load count wrong");

  // Task register load, protected
  AST_TASK: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h00 && byte_data[5:3] == 3'h3 && prot_mode
    |=> dec_valid && dec_clocks == 5'h09)
    else $error("task register load count wrong");

  // Status word load
  AST_MSW: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && byte_valid && at_modrm && two_byte && opcode == 8'h01 && byte_data[5:3] == 3'h6
    |=> dec_valid && dec_clocks == 5'h0B)
    else $error("status word load count wrong");

  // Segment limit load, protected only
  AST_SEG_LIMIT: assert property (@(posedge core_clk) disable iff (rst)
    s_prefix_then(8'h03) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h00))
    else $error("segment limit load count wrong");

  // Effective address waits for mod-r/m
  AST_EA_TWO_STEP: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'h8D) |=> !dec_valid && at_modrm)
    else $error("effective address did not wait for mod-r/m");

  // Effective address, one clock
  AST_EA_ONE_CLOCK: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'h8D) ##1 s_modrm_taken
    |=> dec_valid && dec_clocks == 5'h01)
    else $error("effective address count wrong");

  // Frame exit
  AST_FRAME: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'hC9) |=> dec_valid && dec_clocks == 5'h04)
    else $error("frame exit count wrong");

  // Counted loop
  AST_LOOP: assert property (@(posedge core_clk) disable iff (rst)
    s_first_is(8'hE2) |=> dec_op == xodt_pkg::XODT_OP_COUNTED_LOOP && dec_clocks == 5'h02)
    else $error("loop count wrong");

  // Enable low freezes state and results
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(state) && $stable(dec_valid) && $stable(dec_clocks))
    else $error("state moved while enable low");
endmodule

// file: verilog/xodt_opmap.sv
// Opcode to operation class map
`include "xodt_params.svh"
module xodt_opmap (
  input wire logic two_byte,
  input wire logic [7:0] opcode,
  input wire logic [2:0] reg_field,
  output xodt_pkg::xodt_op_t op,
  output logic needs_modrm
);
  // Reg-field dispatch for system groups
  function automatic xodt_pkg::xodt_op_t grp(input logic [7:0] oc, input logic [2:0] rf);
    grp = xodt_pkg::XODT_OP_NONE;
    if (oc == `XODT_OP_GRP_SYS1 && rf == `XODT_REG_GDT) grp = xodt_pkg::XODT_OP_GLOBAL_DT_LOAD;
    if (oc == `XODT_OP_GRP_SYS1 && rf == `XODT_REG_IDT) grp = xodt_pkg::XODT_OP_INTERRUPT_DT_LOAD;
    if (oc == `XODT_OP_GRP_SYS1 && rf == `XODT_REG_MSW) grp = xodt_pkg::XODT_OP_MACHINE_STATUS_WORD_LOAD;
    if (oc == `XODT_OP_GRP_SYS0 && rf == `XODT_REG_LDT) grp = xodt_pkg::XODT_OP_LOCAL_DT_LOAD;
    if (oc == `XODT_OP_GRP_SYS0 && rf == `XODT_REG_TASK) grp = xodt_pkg::XODT_OP_TASK_REGISTER_LOAD;
  endfunction
  // Class decode
  always_comb begin
    op = xodt_pkg::XODT_OP_NONE;
    needs_modrm = 1'b0;
    if (two_byte) begin
      case (opcode)
        `XODT_OP_PAR_JMP_NEAR: op = xodt_pkg::XODT_OP_JUMP_PARITY_EVEN;
        `XODT_OP_ACC_RIGHTS: begin
          op = xodt_pkg::XODT_OP_LOAD_ACCESS_RIGHTS;
          needs_modrm = 1'b1;
        end
        `XODT_OP_SEG_LIMIT: begin
          op = xodt_pkg::XODT_OP_SEGMENT_LIMIT_LOAD;
          needs_modrm = 1'b1;
        end
        `XODT_OP_PTR_FS: begin
          op = xodt_pkg::XODT_OP_FAR_PTR_LOAD_F_SEG;
          needs_modrm = 1'b1;
        end
        `XODT_OP_PTR_GS: begin
          op = xodt_pkg::XODT_OP_FAR_PTR_LOAD_G_SEG;
          needs_modrm = 1'b1;
        end
        `XODT_OP_PTR_SS: begin
          op = xodt_pkg::XODT_OP_FAR_PTR_LOAD_STACK_SEG;
          needs_modrm = 1'b1;
        end
        `XODT_OP_GRP_SYS0, `XODT_OP_GRP_SYS1: begin
          op = grp(opcode, reg_field);
          needs_modrm = 1'b1;
        end
        default: op = xodt_pkg::XODT_OP_NONE;
      endcase
    end else begin
      case (opcode)
        `XODT_OP_PAR_JMP_SHORT: op = xodt_pkg::XODT_OP_JUMP_PARITY_EVEN;
        `XODT_OP_FLAGS_AH: op = xodt_pkg::XODT_OP_FLAGS_TO_ACCUM_HIGH;
        `XODT_OP_PTR_DS: begin
          op = xodt_pkg::XODT_OP_FAR_PTR_LOAD_DATA_SEG;
          needs_modrm = 1'b1;
        end
        `XODT_OP_PTR_ES: begin
          op = xodt_pkg::XODT_OP_FAR_PTR_LOAD_EXTRA_SEG;
          needs_modrm = 1'b1;
        end
        `XODT_OP_EFF_ADDR: begin
          op = xodt_pkg::XODT_OP_EFFECTIVE_ADDRESS_COMPUTE;
          needs_modrm = 1'b1;
        end
        `XODT_OP_FRAME_EXIT: op = xodt_pkg::XODT_OP_FRAME_EXIT;
        `XODT_OP_LOOP: op = xodt_pkg::XODT_OP_COUNTED_LOOP;
        default: op = xodt_pkg::XODT_OP_NONE;
      endcase
    end
  end
endmodule

// file: verilog/xodt_timing.sv
// Clock-count lookup per operation class and mode
`include "xodt_params.svh"
module xodt_timing (
  input wire xodt_pkg::xodt_op_t op,
  input wire logic prot_mode,
  output logic [4:0] clocks,
  output logic prot_only
);
  // Count table; protected-only classes report prot count in both
  always_comb begin
    clocks = 5'h00;
    prot_only = 1'b0;
    case (op)
      xodt_pkg::XODT_OP_JUMP_PARITY_EVEN: clocks = `XODT_CLK_PAR_JMP;
      xodt_pkg::XODT_OP_FLAGS_TO_ACCUM_HIGH: clocks = `XODT_CLK_FLAGS_AH;
      xodt_pkg::XODT_OP_LOAD_ACCESS_RIGHTS: begin
        clocks = `XODT_CLK_ACC_RIGHTS_P;
        prot_only = 1'b1;
      end
      xodt_pkg::XODT_OP_FAR_PTR_LOAD_DATA_SEG, xodt_pkg::XODT_OP_FAR_PTR_LOAD_EXTRA_SEG,
      xodt_pkg::XODT_OP_FAR_PTR_LOAD_F_SEG, xodt_pkg::XODT_OP_FAR_PTR_LOAD_G_SEG:
        clocks = prot_mode ? `XODT_CLK_PTR_P : `XODT_CLK_PTR_R;
      xodt_pkg::XODT_OP_FAR_PTR_LOAD_STACK_SEG:
        clocks = prot_mode ? `XODT_CLK_PTR_SS_P : `XODT_CLK_PTR_R;
      xodt_pkg::XODT_OP_GLOBAL_DT_LOAD, xodt_pkg::XODT_OP_INTERRUPT_DT_LOAD:
        clocks = `XODT_CLK_DTAB;
      xodt_pkg::XODT_OP_LOCAL_DT_LOAD: begin
        clocks = `XODT_CLK_LDT_P;
        prot_only = 1'b1;
      end
      xodt_pkg::XODT_OP_TASK_REGISTER_LOAD: begin
        clocks = `XODT_CLK_TASK_P;
        prot_only = 1'b1;
      end
      xodt_pkg::XODT_OP_MACHINE_STATUS_WORD_LOAD: clocks = `XODT_CLK_MSW;
      xodt_pkg::XODT_OP_SEGMENT_LIMIT_LOAD: begin
        clocks = `XODT_CLK_SEG_LIMIT_P;
        prot_only = 1'b1;
      end
      xodt_pkg::XODT_OP_EFFECTIVE_ADDRESS_COMPUTE: clocks = `XODT_CLK_EFF_ADDR;
      xodt_pkg::XODT_OP_FRAME_EXIT: clocks = `XODT_CLK_FRAME_EXIT;
      xodt_pkg::XODT_OP_COUNTED_LOOP: clocks = `XODT_CLK_LOOP;
      default: clocks = 5'h00;
    endcase
  end
endmodule
